// >>> hdl/csd_pkg.sv
// Package for the chip-select decode and suspend/resume sequencer
package csd_pkg;
  localparam int unsigned CLK_HZ = 40_000_000;
  localparam int unsigned CODE_W = 5;
  localparam int unsigned NUM_SEL = 20;
  // Select indices; entry value is the bit position of that select within NUM_SEL
  localparam int unsigned SEL_FLOPPY = 0;
  localparam int unsigned SEL_FLOPPY_RATE = 1;
  localparam int unsigned SEL_FLOPPY_OUT = 2;
  localparam int unsigned SEL_CLOCK = 3;
  localparam int unsigned SEL_CLOCK_AE = 4;
  localparam int unsigned SEL_DRV_DEN_LO = 5;
  localparam int unsigned SEL_DRV_DEN_HI = 6;
  localparam int unsigned SEL_DRIVE0 = 7;
  localparam int unsigned SEL_DRIVE1 = 8;
  localparam int unsigned SEL_SERIAL_A = 9;
  localparam int unsigned SEL_SERIAL_B = 10;
  localparam int unsigned SEL_PARALLEL = 11;
  localparam int unsigned SEL_BOOT_ROM = 12;
  localparam int unsigned SEL_KBD = 13;
  localparam int unsigned SEL_COPROC = 14;
  localparam int unsigned SEL_PWR_W0 = 15;
  localparam int unsigned SEL_PWR_W1 = 16;
  localparam int unsigned SEL_PROG = 17;
  localparam int unsigned SEL_EXPMEM = 18;
  localparam int unsigned SEL_SUSPEND = 19;
  // Command code that starts a suspend
  localparam logic [7:0] SUSPEND_CODE = 8'h15;
  // Times as printed
  localparam int unsigned GAP_US = 60;
  localparam int unsigned LOW_US = 60;
  localparam int unsigned WARM_MIN_MS = 500;
  localparam int unsigned WARM_MAX_MS = 501;
  localparam int unsigned RESUME_MIN_US = 60;
  localparam int unsigned RESUME_MAX_US = 91;
  localparam int unsigned STROBE_MAX_NS = 35;
  // Cycle counts, least times rounded up
  localparam int unsigned GAP_CYC = (GAP_US * (CLK_HZ / 1_000_000));
  localparam int unsigned LOW_CYC = (LOW_US * (CLK_HZ / 1_000_000));
  localparam int unsigned WARM_CYC = (WARM_MIN_MS * (CLK_HZ / 1000));
  localparam int unsigned RESUME_CYC = (RESUME_MIN_US * (CLK_HZ / 1_000_000));
  localparam int unsigned CNT_W = 25;
  localparam logic [CNT_W-1:0] CNT_ZERO = 25'h0000000;
  // Reset value of the suspend clock line output
  localparam logic OSC_RST = 1'b1;

  typedef enum logic [2:0] {
    CSD_IDLE, CSD_GAP, CSD_LOW, CSD_SLEEP, CSD_WARM, CSD_RESUME
  } csd_phase_e;

  // Host-side decode inputs, sampled
  typedef struct packed {
    logic page_decode_high;
    logic page_decode_low;
    logic addr_bit_10;
    logic addr_bit_9;
    logic addr_bit_8;
    logic decode_qualifier;
    logic dma_ack_gate;
    logic io_write_n;
    logic addr_latch_en;
  } csd_bus_s;
endpackage

// >>> hdl/csd_decode.sv
// Chip-select decoder with power-unit strobes and suspend/resume sequencer
`timescale 1ns/1ps
// Host pins cross into the clock through two flops, are decoded against
// the select map, and come out as one registered select at a time.
// A write of the suspend code on the suspend select starts the line
// sequence: gap, low gap, sleep, warm-up after a resume request, and a
// companion resume pulse. Timing is counted in clock cycles, so every
// figure carries up to one cycle of quantisation.
module csd_decode #(
  // Entry i (5 bits, top down) is the host code for select i; 0 = unused
  parameter logic [csd_pkg::NUM_SEL*5-1:0] SEL_MAP = {
    5'h01, // Floppy select
    5'h02, // Floppy rate load
    5'h03, // Floppy output load
    5'h04, // Clock select
    5'h05, // Clock address enable
    5'h06, // Drive data enable low
    5'h07, // Drive data enable high
    5'h08, // Drive select 0
    5'h09, // Drive select 1
    5'h0A, // Serial A
    5'h0B, // Serial B
    5'h0C, // Parallel
    5'h0D, // Boot ROM output enable
    5'h0E, // Keyboard controller
    5'h0F, // Coprocessor
    5'h10, // Power-unit write strobe 0
    5'h11, // Power-unit write strobe 1
    5'h12, // Programmable select
    5'h13, // Expanded memory
    5'h14  // Suspend command port
  },
  parameter int unsigned WARM_CYCLES = csd_pkg::WARM_CYC
) (
  input wire logic clk,
  input wire logic rst,
  input wire csd_pkg::csd_bus_s bus_in,
  input wire logic [7:0] data_in,
  input wire logic resume_req,
  output logic [csd_pkg::NUM_SEL-1:0] selects,
  output logic dma_terminal_count,
  output logic suspend_clock_line,
  output logic companion_select,
  output logic companion_resume
);
  // Top bit of the map; entry i sits 5*i bits below it
  localparam int unsigned MAP_TOP = csd_pkg::NUM_SEL * 5 - 1;

  typedef struct packed {
    csd_pkg::csd_bus_s s1;
    csd_pkg::csd_bus_s s2;
    logic [7:0] d1;
    logic [7:0] d2;
    logic [4:0] code_lat;
    logic [csd_pkg::NUM_SEL-1:0] sel;
    logic tc;
    logic osc;
    logic comp_sel;
    logic comp_res;
    csd_pkg::csd_phase_e phase;
    logic [csd_pkg::CNT_W-1:0] cnt;
  } csd_state_s;

  csd_state_s st_r;
  csd_state_s st_nxt;
  logic [4:0] code_now;
  logic [csd_pkg::NUM_SEL-1:0] hit;
  logic qual_ok;
  logic write_low;

  // Code formed from page lines and addr bits 10..8
  assign code_now = {st_r.s2.page_decode_high, st_r.s2.page_decode_low,
                     st_r.s2.addr_bit_10, st_r.s2.addr_bit_9,
                     st_r.s2.addr_bit_8};
  // Qualifier on, DMA gate off, else no address select
  assign qual_ok = st_r.s2.decode_qualifier & ~st_r.s2.dma_ack_gate;
  assign write_low = ~st_r.s2.io_write_n;

  // One compare per select against its table entry
  genvar gi;
  generate
    for (gi = 0; gi < csd_pkg::NUM_SEL; gi++) begin : g_map
      localparam int unsigned HI = MAP_TOP - gi * 5;
      assign hit[gi] = (SEL_MAP[HI -: 5] != 5'h00) &&
                       (SEL_MAP[HI -: 5] == code_now);
      // A live select always came from its own map code
      map_code_a: assert property (@(posedge clk) disable iff (rst)
        selects[gi] |-> $past(code_now) == SEL_MAP[HI -: 5])
        else $error("select from wrong code");
    end
  endgenerate

  // Next state. The decode runs on the second synchroniser stage, so the
  // selects trail the pins by three edges; the data byte rides through
  // the same two stages so that it lines up with the write strobe.
  always_comb begin
    st_nxt = st_r;
    // Two-flop synchroniser for host pins and command data
    st_nxt.s1 = bus_in;
    st_nxt.s2 = st_r.s1;
    st_nxt.d1 = data_in;
    st_nxt.d2 = st_r.d1;
    // Latch address on latch enable; the decode always uses the live code
    if (st_r.s2.addr_latch_en) begin
      st_nxt.code_lat = code_now;
    end
    // Lowest index wins so only one select is ever live
    st_nxt.sel = '0;
    if (qual_ok) begin
      for (int i = csd_pkg::NUM_SEL - 1; i >= 0; i--) begin
        if (hit[i]) begin
          st_nxt.sel = '0;
          st_nxt.sel[i] = 1'b1;
        end
      end
    end
    // Power strobes track the write strobe while decoded
    st_nxt.sel[csd_pkg::SEL_PWR_W0] = st_nxt.sel[csd_pkg::SEL_PWR_W0] &
                                     write_low;
    st_nxt.sel[csd_pkg::SEL_PWR_W1] = st_nxt.sel[csd_pkg::SEL_PWR_W1] &
                                     write_low;
    // Terminal count is the documented exception
    st_nxt.tc = st_r.s2.decode_qualifier & st_r.s2.dma_ack_gate;
    st_nxt.comp_res = 1'b0;
    case (st_r.phase)
      csd_pkg::CSD_IDLE: begin
        // Suspend write of code 15H seen on the suspend select
        if (st_nxt.sel[csd_pkg::SEL_SUSPEND] && write_low &&
            st_r.d2 == csd_pkg::SUSPEND_CODE) begin
          st_nxt.phase = csd_pkg::CSD_GAP;
          st_nxt.cnt = csd_pkg::CNT_ZERO;
          st_nxt.comp_sel = 1'b1;
        end
      end
      // First 60 us: line still high, counting the gap
      csd_pkg::CSD_GAP: begin
        st_nxt.cnt = st_r.cnt + 1'b1;
        if (st_r.cnt == csd_pkg::CNT_W'(csd_pkg::GAP_CYC - 1)) begin
          st_nxt.phase = csd_pkg::CSD_LOW;
          st_nxt.osc = 1'b0;
          st_nxt.cnt = csd_pkg::CNT_ZERO;
        end
      end
      // Low gap; the line then stays low through sleep
      csd_pkg::CSD_LOW: begin
        st_nxt.cnt = st_r.cnt + 1'b1;
        if (st_r.cnt == csd_pkg::CNT_W'(csd_pkg::LOW_CYC - 1)) begin
          st_nxt.phase = csd_pkg::CSD_SLEEP;
          st_nxt.cnt = csd_pkg::CNT_ZERO;
        end
      end
      // Asleep until the resume request arrives
      csd_pkg::CSD_SLEEP: begin
        if (resume_req) begin
          st_nxt.phase = csd_pkg::CSD_WARM;
          st_nxt.cnt = csd_pkg::CNT_ZERO;
        end
      end
      csd_pkg::CSD_WARM: begin
        // Line held until crystal is warm
        st_nxt.cnt = st_r.cnt + 1'b1;
        if (st_r.cnt == csd_pkg::CNT_W'(WARM_CYCLES - 1)) begin
          st_nxt.osc = 1'b1;
          st_nxt.comp_sel = 1'b0;
          st_nxt.phase = csd_pkg::CSD_RESUME;
          st_nxt.cnt = csd_pkg::CNT_ZERO;
        end
      end
      // Companion waits the minimum resume delay, then gets one pulse
      csd_pkg::CSD_RESUME: begin
        st_nxt.cnt = st_r.cnt + 1'b1;
        if (st_r.cnt == csd_pkg::CNT_W'(csd_pkg::RESUME_CYC - 1)) begin
          st_nxt.comp_res = 1'b1;
          st_nxt.phase = csd_pkg::CSD_IDLE;
        end
      end
      // Unused encodings fall back to idle
      default: st_nxt.phase = csd_pkg::CSD_IDLE;
    endcase
  end

  // Single state register, synchronous reset
  always_ff @(posedge clk) begin
    if (rst) begin
      st_r <= '0;
      st_r.osc <= csd_pkg::OSC_RST;
      st_r.phase <= csd_pkg::CSD_IDLE;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Every output comes straight from a flop, so no decode glitch escapes
  assign selects = st_r.sel;
  assign dma_terminal_count = st_r.tc;
  assign suspend_clock_line = st_r.osc;
  assign companion_select = st_r.comp_sel;
  assign companion_resume = st_r.comp_res;

  // Assertions on the decode side
  // Priority pick leaves at most one select live
  one_select_a: assert property (@(posedge clk) disable iff (rst)
    $onehot0(selects)) else $error("two selects live");

  // Qualifier low clears every select one edge later
  qual_gate_a: assert property (@(posedge clk) disable iff (rst)
    !st_r.s2.decode_qualifier |=> selects == '0)
    else $error("select without qualifier");

  // DMA gate blocks every address select
  dma_gate_a: assert property (@(posedge clk) disable iff (rst)
    st_r.s2.dma_ack_gate |=> selects == '0)
    else $error("select during dma gate");

  // Terminal count and selects never overlap
  tc_alone_a: assert property (@(posedge clk) disable iff (rst)
    dma_terminal_count |-> selects == '0)
    else $error("select beside terminal count");

  // Terminal count follows gate and qualifier
  tc_follow_a: assert property (@(posedge clk) disable iff (rst)
    (st_r.s2.dma_ack_gate && st_r.s2.decode_qualifier)
      |=> dma_terminal_count) else $error("terminal count missing");

  // Terminal count drops as soon as either input does
  tc_clear_a: assert property (@(posedge clk) disable iff (rst)
    !(st_r.s2.dma_ack_gate && st_r.s2.decode_qualifier)
      |=> !dma_terminal_count) else $error("terminal count stuck");

  // Power strobes only while the write strobe is low
  pwr_strobe_a: assert property (@(posedge clk) disable iff (rst)
    selects[csd_pkg::SEL_PWR_W0] |-> $past(write_low))
    else $error("power strobe without write");

  pwr1_strobe_a: assert property (@(posedge clk) disable iff (rst)
    selects[csd_pkg::SEL_PWR_W1] |-> $past(write_low))
    else $error("power strobe 1 without write");

  // Write strobe high ends both power strobes at the next edge
  pwr_drop_a: assert property (@(posedge clk) disable iff (rst)
    !write_low |=> !selects[csd_pkg::SEL_PWR_W0] &&
      !selects[csd_pkg::SEL_PWR_W1]) else $error("power strobe stuck");

  // Latched code only moves on a latch enable
  latch_hold_a: assert property (@(posedge clk) disable iff (rst)
    !st_r.s2.addr_latch_en |=> $stable(st_r.code_lat))
    else $error("latched code moved");

  // Companion select rises only when a suspend starts
  comp_rise_a: assert property (@(posedge clk) disable iff (rst)
    $rose(companion_select) |-> st_r.phase == csd_pkg::CSD_GAP)
    else $error("companion select without suspend");

  // Assertions on the suspend and resume sequence
  // The line only falls when the low gap begins
  osc_low_a: assert property (@(posedge clk) disable iff (rst)
    $fell(suspend_clock_line) |-> st_r.phase == csd_pkg::CSD_LOW)
    else $error("line low outside gap");

  // End of the gap count takes the line low
  gap_len_a: assert property (@(posedge clk) disable iff (rst)
    (st_r.phase == csd_pkg::CSD_GAP &&
     st_r.cnt == csd_pkg::CNT_W'(csd_pkg::GAP_CYC - 1))
      |=> !suspend_clock_line) else $error("gap length wrong");

  // Line stays low through the low gap and sleep
  low_hold_a: assert property (@(posedge clk) disable iff (rst)
    (st_r.phase == csd_pkg::CSD_LOW || st_r.phase == csd_pkg::CSD_SLEEP)
      |-> !suspend_clock_line) else $error("line high while asleep");

  // Line is high whenever the sequencer is idle
  line_idle_a: assert property (@(posedge clk) disable iff (rst)
    st_r.phase == csd_pkg::CSD_IDLE |-> suspend_clock_line)
    else $error("line low while idle");

  // Sleep holds until a resume request
  sleep_wait_a: assert property (@(posedge clk) disable iff (rst)
    (st_r.phase == csd_pkg::CSD_SLEEP && !resume_req)
      |=> st_r.phase == csd_pkg::CSD_SLEEP) else $error("woke unasked");

  // Warm-up keeps the line low and the companion selected
  warm_hold_a: assert property (@(posedge clk) disable iff (rst)
    st_r.phase == csd_pkg::CSD_WARM |-> !suspend_clock_line &&
      companion_select) else $error("warm-up cut short");

  // Line returns high only at the end of warm-up
  osc_rise_a: assert property (@(posedge clk) disable iff (rst)
    $rose(suspend_clock_line) |-> st_r.phase == csd_pkg::CSD_RESUME)
    else $error("line rose early");

  // Companion select drops at the end of warm-up
  comp_drop_a: assert property (@(posedge clk) disable iff (rst)
    $fell(companion_select) |-> st_r.phase == csd_pkg::CSD_RESUME)
    else $error("companion select dropped early");

  // Resume pulse comes only after the select is gone
  resume_seq_a: assert property (@(posedge clk) disable iff (rst)
    companion_resume |-> !companion_select)
    else $error("resume while selected");

  // Resume pulse leaves the sequencer idle with the line high
  resume_idle_a: assert property (@(posedge clk) disable iff (rst)
    companion_resume |-> st_r.phase == csd_pkg::CSD_IDLE &&
      suspend_clock_line) else $error("resume pulse out of place");

  // Main scenarios reached
  cv_select: cover property (@(posedge clk) selects != '0);
  cv_strobe: cover property (@(posedge clk) selects[csd_pkg::SEL_PWR_W1]);
  cv_tc: cover property (@(posedge clk) dma_terminal_count);
  cv_low: cover property (@(posedge clk) $fell(suspend_clock_line));
  cv_resume: cover property (@(posedge clk) companion_resume);
endmodule

// >>> verification/csd_host.sv
// Host bus model that drives the decoder's pins
`timescale 1ns/1ps
module csd_host (
  input wire logic clk,
  output csd_pkg::csd_bus_s bus_out,
  output logic [7:0] data_out,
  output logic resume_out
);
  // Idle bus: write strobe high, qualifier and gate off
  initial begin
    bus_out = '0;
    bus_out.io_write_n = 1'b1;
    data_out = 8'h00;
    resume_out = 1'b0;
  end
  // Pins move a fixed delay after the edge, then hold until the next call
  task automatic drive(input logic [4:0] code, input logic qual,
                       input logic gate, input logic wr, input logic [7:0] d);
    @(posedge clk);
    #2;
    {bus_out.page_decode_high, bus_out.page_decode_low, bus_out.addr_bit_10,
     bus_out.addr_bit_9, bus_out.addr_bit_8} = code;
    bus_out.decode_qualifier = qual;
    bus_out.dma_ack_gate = gate; // Low unless a DMA cycle is wanted
    bus_out.io_write_n = ~wr;
    // Released data shows no stale value
    data_out = wr ? d : ~d;
  endtask
  // Address latch pulse ahead of a command write
  task automatic latch_pulse();
    @(posedge clk);
    #2 bus_out.addr_latch_en = 1'b1;
    @(posedge clk);
    #2 bus_out.addr_latch_en = 1'b0;
  endtask
  // Resume request held a few cycles
  task automatic resume();
    @(posedge clk);
    #2 resume_out = 1'b1;
    repeat (4) @(posedge clk);
    #2 resume_out = 1'b0;
  endtask
endmodule

// >>> verification/tb.sv
// Self-checking bench for the select decoder and suspend sequencer
`timescale 1ns/1ps
module tb;
  localparam int WARM = 50;
  logic clk = 1'b0;
  logic rst = 1'b1;
  csd_pkg::csd_bus_s bus;
  logic [7:0] data;
  logic res_req;
  logic [csd_pkg::NUM_SEL-1:0] sel;
  logic tc, line, comp_sel, comp_res;
  int err_count = 0;
  int cmp_count = 0;
  // 40 MHz clock
  always #12.5 clk = ~clk;
  csd_host i_host (.clk(clk), .bus_out(bus), .data_out(data),
    .resume_out(res_req));
  csd_decode #(.WARM_CYCLES(WARM)) i_dut (.clk(clk), .rst(rst),
    .bus_in(bus), .data_in(data), .resume_req(res_req), .selects(sel),
    .dma_terminal_count(tc), .suspend_clock_line(line),
    .companion_select(comp_sel), .companion_resume(comp_res));
  task automatic chk_sel(input logic [csd_pkg::NUM_SEL-1:0] exp);
    cmp_count++;
    if (sel !== exp) begin
      err_count++;
      $display("unexpected %0t selects %h want %h", $time, sel, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected %0t flag %b want %b", $time, got, exp);
    end
  endtask
  task automatic chk_cnt(input int n, input int lo, input int hi);
    cmp_count++;
    if (n < lo || n > hi) begin
      err_count++;
      $display("unexpected %0t count %0d not in %0d..%0d", $time, n, lo, hi);
    end
  endtask
  // Three edges from pin change to registered outputs
  task automatic settle();
    repeat (3) @(posedge clk);
    #1;
  endtask
  // Counts cycles until a signal reaches a level, capped at lim
  task automatic wait_sig(ref logic s, input logic v, input int lim,
                          output int n);
    n = 0;
    while (s !== v && n < lim) begin
      @(posedge clk);
      #1;
      n++;
    end
  endtask
  // Every map code gives its own single select, code 0 gives none
  task automatic t_decode();
    for (int c = 0; c <= csd_pkg::NUM_SEL; c++) begin
      i_host.drive(5'(c), 1'b1, 1'b0, 1'b1, 8'h00);
      settle();
      chk_sel(c == 0 ? '0 : 20'(1) << (c - 1));
      chk_bit(tc, 1'b0);
    end
    $display("test decode done");
  endtask
  // Qualifier and DMA gate decide selects and terminal count
  task automatic t_qual();
    i_host.drive(5'd4, 1'b0, 1'b0, 1'b0, 8'h00);
    settle();
    chk_sel('0);
    chk_bit(tc, 1'b0);
    i_host.drive(5'd4, 1'b1, 1'b1, 1'b0, 8'h00);
    settle();
    chk_sel('0);
    chk_bit(tc, 1'b1);
    i_host.drive(5'd4, 1'b0, 1'b1, 1'b0, 8'h00);
    settle();
    chk_bit(tc, 1'b0);
    $display("test qualifier done");
  endtask
  // Power strobe follows the write strobe
  task automatic t_strobe();
    i_host.drive(5'd17, 1'b1, 1'b0, 1'b0, 8'h00);
    settle();
    chk_sel('0);
    i_host.drive(5'd17, 1'b1, 1'b0, 1'b1, 8'h00);
    settle();
    chk_sel(20'(1) << csd_pkg::SEL_PWR_W1);
    i_host.drive(5'd17, 1'b1, 1'b0, 1'b0, 8'h00);
    settle();
    chk_sel('0);
    $display("test strobe done");
  endtask
  // Latched suspend write, line gap, sleep, warm-up and resume pulse
  task automatic t_suspend();
    int n;
    i_host.drive(5'd20, 1'b1, 1'b0, 1'b0, 8'h00);
    i_host.latch_pulse();
    i_host.drive(5'd20, 1'b1, 1'b0, 1'b1, csd_pkg::SUSPEND_CODE);
    i_host.drive(5'd0, 1'b0, 1'b0, 1'b0, 8'h00);
    wait_sig(comp_sel, 1'b1, 10, n);
    chk_bit(comp_sel, 1'b1);
    wait_sig(line, 1'b0, 3000, n);
    chk_cnt(n, 2390, 2402);
    wait_sig(line, 1'b1, 2500, n);
    chk_cnt(n, 2500, 2500);
    i_host.resume();
    wait_sig(line, 1'b1, 200, n);
    chk_cnt(n, WARM - 6, WARM + 2);
    chk_bit(comp_sel, 1'b0);
    wait_sig(comp_res, 1'b1, 4000, n);
    chk_cnt(n, 2398, 3642);
    @(posedge clk);
    #1;
    chk_bit(comp_res, 1'b0);
    $display("test suspend done");
  endtask
  task automatic stop_test();
    $display("compares %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // Reset for two cycles, then the scenarios
  initial begin
    repeat (2) @(posedge clk);
    #2 rst = 1'b0;
    chk_sel('0);
    chk_bit(line, csd_pkg::OSC_RST);
    t_decode();
    t_qual();
    t_strobe();
    t_suspend();
    stop_test();
  end
  // Run needs about 7500 cycles
  initial begin
    repeat (30000) @(posedge clk);
    err_count++;
    stop_test();
  end
endmodule
